// ---- include/sbf_pkg.sv ----
// Constants, types and states of the serial block transfer framer
// Summary of operation
// [RQ1] Numeric header fields travel as ASCII hex, digit 0 as 30h, A as 41h.
// [RQ2] Types 0-9: first byte 30h read or 38h write, second 30h plus type.
// [RQ3] Bit types 13-22 use first byte 38h or 39h and are write only.
// [RQ4] Only register, input, output, scratchpad, status and I/O bit set/clear accepted.
// [RQ5] Header check equals XOR of header bytes 2 to 15.
// [RQ6] Multi-digit fields go most significant digit first; address in bytes 6-9.
// [RQ7] Data blocks start only after header ACK; direction code picks data flow.
// [RQ8] Up to 256 bytes use one block; longer transfers are split.
// [RQ9] Non-final block: STX, 256 data bytes, ETB, check character.
// [RQ10] Final block: STX, 1 to 256 data bytes, ETX, check character.
// [RQ11] Block check character is XOR over that block's data bytes only.
// [RQ12] Sender of the final block sends EOT after its ACK.
// [RQ13] A master always closes a transaction with EOT.
// [RQ14] Any step that fails aborts the connection with EOT; a target NAKs a bad header or block instead.
// [RQ15] After an enquiry collision wait the back-off, listening for ENQ, then retry.
// [RQ16] No answer to an enquiry counts as a collision too.
// [RQ17] Back-off 300/440, 140/220 or 80/120 ms by rate and ID bit.
// [RQ18] The back-off ID bit steps through the station's own ID.
// [RQ19] Initiator sends a 17-character header after its ENQ is ACKed.
// [RQ20] Target answers ENQ with ACK when idle, NAK when busy.
// [RQ21] Target answers a correct header with ACK, an incorrect one with NAK.
// [RQ22] Each retry moves to the next higher ID bit, starting at bit 0.
package sbf_pkg;
  // Control characters
  localparam logic [7:0] CH_SOH = 8'h01;
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_EOT = 8'h04;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_ETB = 8'h17;
  // ASCII hex digit codes
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_NINE = 8'h39;
  localparam logic [7:0] ASCII_A    = 8'h41;
  localparam logic [7:0] ASCII_F    = 8'h46;
  // Header layout
  localparam logic [7:0] ID_ANY     = 8'hff;
  localparam logic [4:0] HDR_NIB_LO = 5'h01;
  localparam logic [4:0] HDR_ETB_IX = 5'h0f;
  localparam logic [4:0] HDR_LRC_IX = 5'h10;
  localparam logic [4:0] BIT_TYPE_LO = 5'h0d;
  localparam logic [8:0] BLK_BYTES  = 9'h100;
  localparam logic [7:0] ENQ_TRY_MAX = 8'h20;
  // Timing
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned CYC_PER_MS   = CLK_MHZ * 1000;
  localparam int unsigned ENQ_WAIT_MS  = 800;
  localparam int unsigned HDR_ACK_MS   = 2000;
  localparam int unsigned CHAR_WAIT_MS = 800;
  localparam int unsigned BO_300_LO_MS = 300;
  localparam int unsigned BO_300_HI_MS = 440;
  localparam int unsigned BO_600_LO_MS = 140;
  localparam int unsigned BO_600_HI_MS = 220;
  localparam int unsigned BO_FST_LO_MS = 80;
  localparam int unsigned BO_FST_HI_MS = 120;

  typedef enum logic [1:0] {BAUD_300 = 2'h0, BAUD_600 = 2'h1, BAUD_FAST = 2'h2} sbf_baud_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sbf_byte_t;

  typedef struct packed {
    logic [7:0]  tid;
    logic        write;
    logic [4:0]  mtype;
    logic [15:0] addr;
    logic [7:0]  nblk;
    logic [7:0]  last;
    logic [7:0]  sid;
  } sbf_hdr_t;

  typedef enum logic [12:0] {
    ST_IDLE     = 13'h0001,
    ST_SEND     = 13'h0002,
    ST_CLOSE    = 13'h0004,
    ST_ABORT    = 13'h0008,
    ST_ENQ_WAIT = 13'h0010,
    ST_BACKOFF  = 13'h0020,
    ST_HDR_TX   = 13'h0040,
    ST_HDR_ACK  = 13'h0080,
    ST_HDR_RX   = 13'h0100,
    ST_BLK_TX   = 13'h0200,
    ST_BLK_ACK  = 13'h0400,
    ST_BLK_RX   = 13'h0800,
    ST_EOT_WAIT = 13'h1000
  } sbf_state_t;
endpackage

// ---- rtl/sbf_hex_codec.sv ----
// Nibble to ASCII hex and ASCII hex to nibble conversion
`timescale 1ns/10ps
module sbf_hex_codec (
  input  wire logic [3:0] nib_in,
  input  wire logic [7:0] chr_in,
  output logic      [7:0] chr_out,
  output logic      [3:0] nib_out,
  output logic            nib_ok
);
  import sbf_pkg::*;

  // Encode one digit and decode one received character
  always_comb begin
    if (nib_in < 4'ha) begin
      chr_out = ASCII_ZERO + {4'h0, nib_in}; // [RQ1]
    end else begin
      chr_out = ASCII_A + {4'h0, nib_in - 4'ha}; // [RQ1]
    end
    nib_out = chr_in[3:0];
    nib_ok  = 1'b1;
    if (chr_in >= ASCII_A && chr_in <= ASCII_F) begin
      nib_out = chr_in[3:0] + 4'h9; // [RQ1]
    end else if (chr_in < ASCII_ZERO || chr_in > ASCII_NINE) begin
      nib_ok = 1'b0;
    end
  end
endmodule

// ---- rtl/sbf_backoff.sv ----
// Collision back-off timer that steps through the station ID bits
`timescale 1ns/10ps
module sbf_backoff #(
  parameter int unsigned MS_CYC = sbf_pkg::CYC_PER_MS
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic             restart,
  input  wire logic [7:0]       own_id,
  input  wire sbf_pkg::sbf_baud_t baud,
  output logic                  done
);
  import sbf_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic [2:0]  bit_ix;
    logic        run;
    logic        done;
  } sbf_bo_t;

  sbf_bo_t r;
  sbf_bo_t s;

  // Back-off length for a rate and an ID bit value
  function automatic logic [31:0] bo_load(input sbf_baud_t b, input logic one);
    int unsigned ms;
    case (b)
      BAUD_300: ms = one ? BO_300_HI_MS : BO_300_LO_MS; // [RQ17]
      BAUD_600: ms = one ? BO_600_HI_MS : BO_600_LO_MS; // [RQ17]
      default:  ms = one ? BO_FST_HI_MS : BO_FST_LO_MS; // [RQ17]
    endcase
    return 32'(ms * MS_CYC);
  endfunction

  // Next state: load on start, count down, pulse done at the end
  always_comb begin
    logic [2:0] ix;
    s      = r;
    ix     = restart ? 3'h0 : r.bit_ix; // [RQ22]
    s.bit_ix = ix;
    s.done = 1'b0;
    if (start) begin
      s.cnt    = bo_load(baud, own_id[ix]); // [RQ18]
      s.bit_ix = ix + 3'h1; // [RQ22]
      s.run    = 1'b1;
    end else if (r.run) begin
      if (r.cnt <= 32'h1) begin
        s.run  = 1'b0;
        s.done = 1'b1;
      end else begin
        s.cnt = r.cnt - 32'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= s;
    end
  end

  assign done = r.done;
endmodule

// ---- rtl/sbf_framer.sv ----
// Block transfer framer: enquiry, header, data blocks and termination
`timescale 1ns/10ps
module sbf_framer #(
  parameter int unsigned MS_CYC = sbf_pkg::CYC_PER_MS
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic [7:0]         own_id,
  input  wire sbf_pkg::sbf_baud_t baud,
  input  wire logic               master_mode,
  input  wire logic               local_busy,
  input  wire sbf_pkg::sbf_byte_t rx,
  output sbf_pkg::sbf_byte_t      tx,
  input  wire logic               tx_ready,
  input  wire logic               req_start,
  input  wire sbf_pkg::sbf_hdr_t  req_hdr,
  output logic                    src_req,
  input  wire sbf_pkg::sbf_byte_t src_data,
  output sbf_pkg::sbf_byte_t      snk,
  output sbf_pkg::sbf_hdr_t       hdr_out,
  output logic                    hdr_valid,
  output logic                    busy,
  output logic                    done,
  output logic                    error
);
  import sbf_pkg::*;

  localparam logic [31:0] T_ENQ  = 32'(ENQ_WAIT_MS * MS_CYC);
  localparam logic [31:0] T_HACK = 32'(HDR_ACK_MS * MS_CYC);
  localparam logic [31:0] T_CHAR = 32'(CHAR_WAIT_MS * MS_CYC);

  typedef struct packed {
    sbf_state_t  st;
    sbf_state_t  ret;
    logic        src;
    sbf_hdr_t    hdr;
    logic [4:0]  idx;
    logic [1:0]  ph;
    logic [7:0]  block_check_character;
    logic [7:0]  pend;
    logic [8:0]  blk;
    logic [8:0]  cnt;
    logic [55:0] sr;
    logic        bad;
    logic        wait_d;
    logic        have;
    logic [7:0]  tries;
    logic [31:0] tmr;
    sbf_byte_t   tx;
    sbf_byte_t   snk;
    logic        src_req;
    logic        hdr_valid;
    logic        busy;
    logic        done;
    logic        err;
    logic        bo_start;
    logic        bo_clr;
  } sbf_regs_t;

  sbf_regs_t   r;
  sbf_regs_t   s;
  logic        tfree;
  logic        tmo;
  logic        bo_done;
  logic [55:0] hvec;
  logic [55:0] hsh;
  logic [7:0]  hchr;
  logic [3:0]  rnib;
  logic        rnib_ok;
  sbf_hdr_t    rh;
  logic [8:0]  cur_len;
  logic [8:0]  rh_total;

  // Memory types this station serves; bit functions only as writes
  function automatic logic type_ok(input logic wr, input logic [7:0] code);
    logic ok;
    ok = 1'b0;
    if (code[6:5] == 2'h0) begin
      case (code[4:0])
        5'h01, 5'h02, 5'h03, 5'h06, 5'h09: ok = 1'b1; // [RQ4]
        5'h0d, 5'h0e, 5'h11, 5'h12: ok = wr; // [RQ3] [RQ4]
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  // Total blocks: complete ones plus a short last one
  function automatic logic [8:0] blocks(input logic [7:0] nb, input logic [7:0] lb);
    return {1'b0, nb} + {8'h0, lb != 8'h0}; // [RQ8]
  endfunction

  // Header digits in send order; type byte holds the write flag in bit 7
  assign hvec = {r.hdr.tid, r.hdr.write, 2'h0, r.hdr.mtype, r.hdr.addr,
                 r.hdr.nblk, r.hdr.last, r.hdr.sid}; // [RQ2] [RQ3]
  assign hsh  = hvec << {r.idx - HDR_NIB_LO, 2'h0}; // [RQ6]

  sbf_hex_codec u_codec (
    .nib_in  (hsh[55:52]),
    .chr_in  (rx.data),
    .chr_out (hchr),
    .nib_out (rnib),
    .nib_ok  (rnib_ok)
  );

  sbf_backoff #(
    .MS_CYC (MS_CYC)
  ) u_backoff (
    .clk     (clk),
    .rst     (rst),
    .start   (r.bo_start),
    .restart (r.bo_clr),
    .own_id  (own_id),
    .baud    (baud),
    .done    (bo_done)
  );

  // Received header fields, complete after the last digit
  always_comb begin
    rh.tid   = r.sr[55:48];
    rh.write = r.sr[47];
    rh.mtype = r.sr[44:40];
    rh.addr  = r.sr[39:24]; // [RQ6]
    rh.nblk  = r.sr[23:16];
    rh.last  = r.sr[15:8];
    rh.sid   = r.sr[7:0];
  end

  // Transmit slot, timeout and current block length
  assign tfree    = !r.tx.valid || tx_ready;
  assign tmo      = (r.tmr == 32'h0);
  assign rh_total = blocks(rh.nblk, rh.last);
  assign cur_len  = (r.blk == 9'h1 && r.hdr.last != 8'h0) ? {1'b0, r.hdr.last} : BLK_BYTES; // [RQ9] [RQ10]

  // Protocol sequencer
  always_comb begin
    s           = r;
    s.src_req   = 1'b0;
    s.snk.valid = 1'b0;
    s.hdr_valid = 1'b0;
    s.done      = 1'b0;
    s.err       = 1'b0;
    s.bo_start  = 1'b0;
    s.bo_clr    = 1'b0;
    if (tx_ready) begin
      s.tx.valid = 1'b0;
    end
    if (!tmo) begin
      s.tmr = r.tmr - 32'h1;
    end
    case (r.st)
      ST_IDLE: begin
        if (rx.valid && rx.data == CH_ENQ) begin
          s.src  = 1'b0;
          s.pend = local_busy ? CH_NAK : CH_ACK; // [RQ20]
          s.ret  = local_busy ? ST_IDLE : ST_HDR_RX;
          s.idx  = 5'h0;
          s.tmr  = T_CHAR;
          s.st   = ST_SEND;
        end else if (req_start) begin
          s.src       = 1'b1;
          s.hdr       = req_hdr;
          s.hdr.sid   = own_id;
          s.hdr.write = req_hdr.write || req_hdr.mtype >= BIT_TYPE_LO; // [RQ3]
          s.tries     = 8'h0;
          s.bo_clr    = 1'b1; // [RQ22]
          s.pend      = CH_ENQ;
          s.ret       = ST_ENQ_WAIT;
          s.tmr       = T_ENQ;
          s.st        = ST_SEND;
        end
      end
      ST_SEND: begin
        // One control character, then on to the stored state
        if (tfree) begin
          s.tx = '{valid: 1'b1, data: r.pend};
          s.st = r.ret;
        end
      end
      ST_CLOSE: begin
        s.pend = CH_EOT; // [RQ12] [RQ13]
        s.ret  = ST_IDLE;
        s.done = 1'b1;
        s.st   = ST_SEND;
      end
      ST_ABORT: begin
        s.pend = CH_EOT; // [RQ14]
        s.ret  = ST_IDLE;
        s.err  = 1'b1;
        s.st   = ST_SEND;
      end
      ST_ENQ_WAIT: begin
        if (rx.valid && rx.data == CH_ACK) begin
          s.idx = 5'h0; // [RQ19]
          s.block_check_character = 8'h0;
          s.st  = ST_HDR_TX;
        end else if (rx.valid && rx.data != CH_ENQ) begin
          s.st = ST_ABORT; // [RQ14]
        end else if (rx.valid || tmo) begin
          // Enquiry crossed ours or nobody answered: collision
          s.tries = r.tries + 8'h1; // [RQ15] [RQ16]
          if (r.tries == ENQ_TRY_MAX) begin
            s.st = ST_ABORT; // [RQ14]
          end else begin
            s.bo_start = 1'b1; // [RQ18]
            s.st       = ST_BACKOFF;
          end
        end
      end
      ST_BACKOFF: begin
        // Listen for the other side while waiting
        if (rx.valid && rx.data == CH_ENQ) begin
          s.src  = 1'b0;
          s.pend = local_busy ? CH_NAK : CH_ACK; // [RQ15] [RQ20]
          s.ret  = local_busy ? ST_IDLE : ST_HDR_RX;
          s.idx  = 5'h0;
          s.tmr  = T_CHAR;
          s.st   = ST_SEND;
        end else if (bo_done) begin
          s.pend = CH_ENQ; // [RQ15]
          s.ret  = ST_ENQ_WAIT;
          s.tmr  = T_ENQ;
          s.st   = ST_SEND;
        end
      end
      ST_HDR_TX: begin
        if (tfree) begin
          s.tx.valid = 1'b1;
          s.idx      = r.idx + 5'h1;
          if (r.idx == 5'h0) begin
            s.tx.data = CH_SOH; // [RQ19]
          end else if (r.idx == HDR_ETB_IX) begin
            s.tx.data = CH_ETB;
          end else if (r.idx == HDR_LRC_IX) begin
            s.tx.data = r.block_check_character; // [RQ5]
            s.tmr     = T_HACK;
            s.st      = ST_HDR_ACK;
          end else begin
            s.tx.data = hchr; // [RQ1] [RQ6]
            s.block_check_character     = r.block_check_character ^ hchr; // [RQ5]
          end
        end
      end
      ST_HDR_ACK: begin
        if (rx.valid && rx.data == CH_ACK) begin
          s.blk    = blocks(r.hdr.nblk, r.hdr.last); // [RQ8]
          s.ph     = 2'h0;
          s.wait_d = 1'b0;
          s.have   = 1'b0;
          s.tmr    = T_CHAR;
          s.st     = r.hdr.write ? ST_BLK_TX : ST_BLK_RX; // [RQ7]
        end else if (rx.valid || tmo) begin
          s.st = ST_ABORT; // [RQ14]
        end
      end
      ST_HDR_RX: begin
        if (tmo) begin
          s.st = ST_IDLE;
        end else if (rx.valid) begin
          s.tmr = T_CHAR;
          s.idx = r.idx + 5'h1;
          if (r.idx == 5'h0) begin
            s.idx = (rx.data == CH_SOH) ? 5'h1 : 5'h0;
            s.block_check_character = 8'h0;
            s.bad = 1'b0;
          end else if (r.idx == HDR_ETB_IX) begin
            s.bad = r.bad || rx.data != CH_ETB;
          end else if (r.idx == HDR_LRC_IX) begin
            s.ret = ST_IDLE;
            if (!r.bad && rx.data == r.block_check_character && rh_total != 9'h0 && // [RQ5]
                (rh.tid == own_id || rh.tid == ID_ANY) &&
                type_ok(rh.write, r.sr[47:40])) begin // [RQ3] [RQ4]
              s.pend      = CH_ACK; // [RQ21]
              s.hdr       = rh;
              s.hdr_valid = 1'b1;
              s.blk       = rh_total;
              s.ph        = 2'h0;
              s.wait_d    = 1'b0;
              s.have      = 1'b0;
              s.ret       = rh.write ? ST_BLK_RX : ST_BLK_TX; // [RQ7]
            end else begin
              s.pend = CH_NAK; // [RQ21]
            end
            s.st = ST_SEND;
          end else begin
            s.sr  = {r.sr[51:0], rnib}; // [RQ1] [RQ6]
            s.bad = r.bad || !rnib_ok;
            s.block_check_character = r.block_check_character ^ rx.data; // [RQ5]
          end
        end
      end
      ST_BLK_TX: begin
        // Fetch one byte at a time from the local side
        if (r.ph == 2'h1 && !r.wait_d && !r.have) begin
          s.src_req = 1'b1;
          s.wait_d  = 1'b1;
        end
        if (r.wait_d && src_data.valid) begin
          s.pend   = src_data.data;
          s.wait_d = 1'b0;
          s.have   = 1'b1;
        end
        if (tfree) begin
          case (r.ph)
            2'h0: begin
              s.tx  = '{valid: 1'b1, data: CH_STX}; // [RQ9] [RQ10]
              s.block_check_character = 8'h0; // [RQ11]
              s.cnt = cur_len; // [RQ8]
              s.ph  = 2'h1;
            end
            2'h1: begin
              if (r.have) begin
                s.tx   = '{valid: 1'b1, data: r.pend};
                s.block_check_character  = r.block_check_character ^ r.pend; // [RQ11]
                s.have = 1'b0;
                s.cnt  = r.cnt - 9'h1;
                if (r.cnt == 9'h1) begin
                  s.ph = 2'h2;
                end
              end
            end
            2'h2: begin
              s.tx = '{valid: 1'b1, data: (r.blk == 9'h1) ? CH_ETX : CH_ETB}; // [RQ9] [RQ10]
              s.ph = 2'h3;
            end
            default: begin
              s.tx  = '{valid: 1'b1, data: r.block_check_character}; // [RQ11]
              s.tmr = T_CHAR;
              s.st  = ST_BLK_ACK;
            end
          endcase
        end
      end
      ST_BLK_ACK: begin
        if (rx.valid && rx.data == CH_ACK) begin
          s.blk = r.blk - 9'h1;
          s.ph  = 2'h0;
          s.st  = (r.blk == 9'h1) ? ST_CLOSE : ST_BLK_TX; // [RQ12]
        end else if (rx.valid || tmo) begin
          s.st = ST_ABORT; // [RQ14]
        end
      end
      ST_BLK_RX: begin
        if (tmo) begin
          s.st = ST_ABORT; // [RQ14]
        end else if (rx.valid) begin
          s.tmr = T_CHAR;
          case (r.ph)
            2'h0: begin
              s.block_check_character = 8'h0; // [RQ11]
              s.cnt = cur_len; // [RQ9] [RQ10]
              s.bad = 1'b0;
              s.ph  = 2'h1;
              if (rx.data != CH_STX) begin
                s.st = (rx.data == CH_EOT) ? ST_IDLE : ST_ABORT; // [RQ14]
                s.err = (rx.data == CH_EOT);
              end
            end
            2'h1: begin
              s.snk = rx; // [RQ7]
              s.block_check_character = r.block_check_character ^ rx.data; // [RQ11]
              s.cnt = r.cnt - 9'h1;
              if (r.cnt == 9'h1) begin
                s.ph = 2'h2;
              end
            end
            2'h2: begin
              s.bad = rx.data != ((r.blk == 9'h1) ? CH_ETX : CH_ETB); // [RQ9] [RQ10]
              s.ph  = 2'h3;
            end
            default: begin
              s.ph = 2'h0;
              if (!r.bad && rx.data == r.block_check_character) begin
                s.pend = CH_ACK;
                s.blk  = r.blk - 9'h1;
                s.st   = ST_SEND;
                if (r.blk != 9'h1) begin
                  s.ret = ST_BLK_RX;
                end else if (r.src && master_mode) begin
                  s.ret = ST_CLOSE; // [RQ13]
                end else begin
                  s.ret = ST_EOT_WAIT; // [RQ12]
                end
              end else if (r.src) begin
                s.st = ST_ABORT; // [RQ14]
              end else begin
                s.pend = CH_NAK;
                s.ret  = ST_EOT_WAIT;
                s.err  = 1'b1;
                s.st   = ST_SEND;
              end
            end
          endcase
        end
      end
      ST_EOT_WAIT: begin
        if (rx.valid && rx.data == CH_EOT) begin
          s.done = 1'b1; // [RQ12]
          s.st   = ST_IDLE;
        end else if (tmo) begin
          s.err = 1'b1;
          s.st  = ST_IDLE;
        end
      end
      default: begin
        s.st = ST_IDLE;
      end
    endcase
    s.busy = (s.st != ST_IDLE);
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      r     <= '0;
      r.st  <= ST_IDLE;
      r.ret <= ST_IDLE;
    end else begin
      r <= s;
    end
  end

  // Outputs straight from the state register
  assign tx        = r.tx;
  assign src_req   = r.src_req;
  assign snk       = r.snk;
  assign hdr_out   = r.hdr;
  assign hdr_valid = r.hdr_valid;
  assign busy      = r.busy;
  assign done      = r.done;
  assign error     = r.err;
endmodule

// ---- test/sbf_framer_monitor.sv ----
// Port checker for the block transfer framer
`timescale 1ns/10ps
module sbf_framer_monitor
  import sbf_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               local_busy,
  input wire sbf_pkg::sbf_byte_t rx,
  input wire sbf_pkg::sbf_byte_t tx,
  input wire logic               tx_ready,
  input wire logic               req_start,
  input wire logic               src_req,
  input wire sbf_pkg::sbf_byte_t snk,
  input wire sbf_pkg::sbf_hdr_t  hdr_out,
  input wire logic               hdr_valid,
  input wire logic               busy,
  input wire logic               done,
  input wire logic               error
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Enquiry, header and start answers
  enq_answer_a: assert property (!busy && !req_start && !tx.valid && rx == {1'b1, CH_ENQ} |-> ##2
    tx == {1'b1, local_busy ? CH_NAK : CH_ACK}) else $error("bad enquiry answer");
  hdr_ack_a: assert property (hdr_valid |-> ##1 tx == {1'b1, CH_ACK})
    else $error("header not acked");
  start_enq_a: assert property (!busy && req_start && !rx.valid |-> ##2 tx == {1'b1, CH_ENQ})
    else $error("no enquiry after start");
  // Accepted header contents
  hdr_type_a: assert property (hdr_valid |-> hdr_out.mtype inside {1, 2, 3, 6, 9, 13, 14, 17, 18})
    else $error("bad type accepted");
  bit_write_a: assert property (hdr_valid && hdr_out.mtype >= 5'h0d |-> hdr_out.write)
    else $error("bit type read accepted");
  // Link holding and data flow
  tx_hold_a: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
    else $error("tx changed in stall");
  data_busy_a: assert property (src_req || snk.valid |-> busy)
    else $error("data while idle");
  end_pulse_a: assert property (done || error |=> !done && !error)
    else $error("end pulse too long");
  cover property (hdr_valid);
  cover property (done);
  cover property (error);
endmodule
bind sbf_framer sbf_framer_monitor u_mon (.clk(clk), .rst(rst), .local_busy(local_busy), .rx(rx), .tx(tx),
  .tx_ready(tx_ready), .req_start(req_start), .src_req(src_req), .snk(snk), .hdr_out(hdr_out),
  .hdr_valid(hdr_valid), .busy(busy), .done(done), .error(error));

// ---- test/sbf_peer.sv ----
// Peer station model on the serial side
`timescale 1ns/10ps
module sbf_peer (
  input  wire logic               clk,
  input  wire logic               slow,
  input  wire sbf_pkg::sbf_byte_t tx,
  output logic                    tx_ready,
  output sbf_pkg::sbf_byte_t      rx
);
  logic [7:0] got[$];
  logic       ph = 1'b0;
  initial rx = '0;
  // Take characters; when slow, stall every other cycle
  always @(posedge clk) begin
    ph <= ~ph;
    if (tx.valid && tx_ready) got.push_back(tx.data);
  end
  assign tx_ready = !slow || ph;
  // One character per cycle, called at a falling edge
  task automatic send(input logic [7:0] c);
    rx <= {1'b1, c};
    @(negedge clk);
  endtask
  // Released line shows the inverse of the last character
  task automatic rel();
    rx <= {1'b0, ~rx.data};
    @(negedge clk);
  endtask
endmodule

// ---- test/sbf_framer_tb.sv ----
// Self-checking bench for the block transfer framer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module sbf_framer_tb;
  import sbf_pkg::*;
  typedef struct packed {logic [7:0] ty; logic [7:0] bad; logic [7:0] ans;} sbf_row_t;
  logic clk = 1'b0, rst = 1'b1, mm = 1'b0, lb = 1'b0, slow = 1'b0, req_start = 1'b0;
  logic [7:0] own_id = 8'h02;
  sbf_hdr_t req_hdr = '0, hdr_out;
  sbf_byte_t src_data = '0, tx, rx, snk;
  logic tx_ready, src_req, hdr_valid, busy, done, error;
  int n_errors = 0, checks_done = 0, n_done = 0, n_err = 0, k = 0, j = 0;
  logic [7:0] hb[17], b, l, s[$];
  time t0;
  sbf_row_t rows[8] = '{'{8'h01, 0, CH_ACK}, '{8'h82, 0, CH_ACK}, '{8'h04, 0, CH_NAK}, '{8'h8d, 0, CH_ACK},
    '{8'h0d, 0, CH_NAK}, '{8'h90, 0, CH_NAK}, '{8'h91, 0, CH_ACK}, '{8'h81, 1, CH_NAK}};
  always #5 clk = ~clk;
  sbf_framer #(.MS_CYC(2)) DUT (.clk(clk), .rst(rst), .own_id(own_id), .baud(BAUD_FAST), .master_mode(mm),
    .local_busy(lb), .rx(rx), .tx(tx), .tx_ready(tx_ready), .req_start(req_start), .req_hdr(req_hdr),
    .src_req(src_req), .src_data(src_data), .snk(snk), .hdr_out(hdr_out), .hdr_valid(hdr_valid),
    .busy(busy), .done(done), .error(error));
  sbf_peer peer (.clk(clk), .slow(slow), .tx(tx), .tx_ready(tx_ready), .rx(rx));
  // Sink bytes and end pulses
  always @(posedge clk) begin
    if (snk.valid) s.push_back(snk.data);
    n_done += done;
    n_err += error;
  end
  // Local source answers each request with a counting byte
  always @(negedge clk) begin
    src_data <= {src_req, k[7:0]};
    if (src_req) k++;
  end
  // Next sent character, unknown on timeout
  task automatic want(input string nm, input logic [7:0] e);
    b = 8'hxx;
    for (int i = 0; i < 5000 && peer.got.size() == 0; i++) @(negedge clk);
    if (peer.got.size() != 0) b = peer.got.pop_front();
    `CHK(nm, e, b)
  endtask
  // Header image: ASCII digits MSB first, XOR of the digits
  task automatic mk(input logic [7:0] tg, ty, input logic [15:0] ad, input logic [7:0] nb, ls, sr);
    logic [55:0] v;
    v = {tg, ty, ad, nb, ls, sr};
    hb[0] = CH_SOH;
    hb[15] = CH_ETB;
    hb[16] = 8'h00;
    for (int i = 1; i < 15; i++) begin
      hb[i] = (v[59-4*i -: 4] < 4'ha) ? 8'h30 + v[59-4*i -: 4] : 8'h37 + v[59-4*i -: 4];
      hb[16] ^= hb[i];
    end
  endtask
  task automatic hdr(input logic [7:0] ty, nb, ls, bad);
    mk(own_id, ty, 16'h03da, nb, ls, 8'h09);
    hb[16] ^= bad;
    peer.send(CH_ENQ);
    peer.rel();
    want("enquiry answer", CH_ACK);
    foreach (hb[i]) peer.send(hb[i]);
    peer.rel();
  endtask
  // Abort any open transfer and flush the link
  task automatic idle();
    peer.send(CH_EOT);
    peer.rel();
    for (int i = 0; i < 9000 && busy !== 1'b0; i++) @(negedge clk);
    repeat (4) @(negedge clk);
    peer.got.delete();
  endtask
  // Expect one outgoing block of counting bytes
  task automatic tblk(input int n, input logic [7:0] ec);
    want("block start", CH_STX);
    l = 8'h00;
    for (int i = 0; i < n; i++) begin
      want("data", j[7:0]);
      l ^= j[7:0];
      j++;
    end
    want("block end", ec);
    want("block check", l);
    peer.send(CH_ACK);
    peer.rel();
  endtask
  task automatic go();
    req_start = 1'b1;
    @(negedge clk);
    req_start = 1'b0;
    want("enquiry", CH_ENQ);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (20) @(negedge clk);
    `CHK("busy", 1'b0, busy)
    `CHK("tx valid", 1'b0, tx.valid)
    rst = 1'b0;
    $display("reset done");
    foreach (rows[r]) begin
      hdr(rows[r].ty, 8'h00, 8'h01, rows[r].bad);
      want("header answer", rows[r].ans);
      idle();
    end
    $display("type table done");
    hdr(8'h81, 8'h00, 8'h02, 8'h00);
    want("header answer", CH_ACK);
    `CHK("address", 16'h03da, hdr_out.addr)
    peer.send(CH_STX);
    peer.send(8'ha5);
    peer.send(8'h3c);
    peer.send(CH_ETX);
    peer.send(8'h99);
    peer.rel();
    want("block answer", CH_ACK);
    `CHK("sink byte", 8'h3c, s[1])
    idle();
    `CHK("done count", 1, n_done)
    lb = 1'b1;
    peer.send(CH_ENQ);
    peer.rel();
    want("busy answer", CH_NAK);
    lb = 1'b0;
    idle();
    $display("target done");
    slow = 1'b1;
    req_hdr = '{8'h01, 1'b1, 5'h01, 16'h03da, 8'h01, 8'h01, 8'h00};
    go();
    peer.send(CH_ACK);
    peer.rel();
    mk(8'h01, 8'h81, 16'h03da, 8'h01, 8'h01, own_id);
    foreach (hb[i]) want("header byte", hb[i]);
    peer.send(CH_ACK);
    peer.rel();
    j = k;
    tblk(256, CH_ETB);
    tblk(1, CH_ETX);
    want("close", CH_EOT);
    slow = 1'b0;
    mm = 1'b1;
    req_hdr.write = 1'b0;
    req_hdr.nblk = 8'h00;
    go();
    peer.send(CH_ACK);
    repeat (20) peer.rel();
    peer.got.delete();
    peer.send(CH_ACK);
    peer.send(CH_STX);
    peer.send(8'h5a);
    peer.send(CH_ETX);
    peer.send(8'h5a);
    peer.rel();
    want("read answer", CH_ACK);
    want("master close", CH_EOT);
    $display("initiator done");
    go();
    t0 = $time;
    want("retry", CH_ENQ);
    `CHK("gap bit 0", 1'b1, $time - t0 >= 17600 && $time - t0 < 18000)
    t0 = $time;
    want("retry", CH_ENQ);
    `CHK("gap bit 1", 1'b1, $time - t0 >= 18400 && $time - t0 < 18800)
    peer.send(CH_NAK);
    peer.rel();
    want("abort", CH_EOT);
    `CHK("error count", 5, n_err)
    $display("collision done");
    summarize();
  end
endmodule
